// ==== verilog/dio_event_map.vh ====
// Register offsets, field positions, reset values and timing counts of the
// digital input/output event counter card. Definitions only.
`ifndef DIO_EVENT_MAP_VH
`define DIO_EVENT_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define A_OUT_DRIVE     8'h00
`define A_OUT_STAGE     8'h01
`define A_OUT_POINT     8'h02
`define A_IN_LIVE       8'h03
`define A_IN_CAPTURE    8'h04
`define A_STATUS        8'h05
`define A_CONFIG        8'h06
`define A_EDGE_SEL      8'h07
`define A_BOTH_SEL      8'h08
`define A_WRAP_SEL      8'h09
`define A_MASK          8'h0a
`define A_RECORD        8'h0b
`define A_STROBE        8'h0c
`define A_COUNT_BASE    8'h20
`define A_RELOAD_BASE   8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CFG_EXT_BIT     0
`define CFG_RISE_BIT    8
`define ST_WAIT_BIT     0
`define WR_STROBE_BIT   16
`define PT_VALUE_BIT    0
`define PT_SEL_LSB      8
`define PT_SEL_MSB      11
`define SB_OUT_BIT      0
`define SB_IN_BIT       1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RST_FIELD       16'h0000
`define RST_COUNT       8'h00
`define SCAN_PERIOD_NS  16000
`define CLK_PERIOD_NS   40
`define SCAN_CYCLES     ((`SCAN_PERIOD_NS / `CLK_PERIOD_NS) / 16)

`endif

// ==== verilog/dio_event_card.v ====
// Digital input/output card with per-point event counters and scaled-event record.
// Assumes one clock, a host register port with read data one cycle later,
// and unsynchronised field inputs and strobe pin.
`timescale 1ns/1ps
`include "dio_event_map.vh"

module dio_event_card #(
    parameter integer SCAN_CYCLES = `SCAN_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Host register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    input  wire        second_word,
    input  wire        irq_enable,
    output reg  [31:0] rdata,
    // Field pins
    input  wire [15:0] field_in,
    input  wire        ext_strobe,
    output reg  [15:0] field_out,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg  [15:0] in_s1_q;
    reg  [15:0] in_s2_q;
    reg  [15:0] in_s3_q;
    reg  [15:0] in_q;
    reg  [2:0]  stb_s_q;
    reg         stb_q;
    reg         stb_prev_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_s1_q <= `RST_FIELD;
            in_s2_q <= `RST_FIELD;
            in_s3_q <= `RST_FIELD;
            in_q    <= `RST_FIELD;
        end else begin
            in_s1_q <= field_in;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
            in_q    <= (in_s2_q & in_s3_q) | (in_q & (in_s2_q ^ in_s3_q));
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stb_s_q    <= 3'h0;
            stb_q      <= 1'b0;
            stb_prev_q <= 1'b0;
        end else begin
            stb_s_q    <= {stb_s_q[1:0], ext_strobe};
            stb_q      <= (stb_s_q[1] == stb_s_q[2]) ? stb_s_q[2] : stb_q;
            stb_prev_q <= stb_q;
        end
    end

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    reg  [15:0] stage_q;
    reg  [15:0] edge_sel_q;
    reg  [15:0] both_sel_q;
    reg  [15:0] wrap_sel_q;
    reg  [15:0] mask_q;
    reg  [15:0] record_q;
    reg  [15:0] capture_q;
    reg         ext_en_q;
    reg         rise_q;
    reg         wait_q;
    reg         irq_ff_q;

    wire        with_stb    = wdata[`WR_STROBE_BIT];
    wire        wr_field    = wr && (addr == `A_OUT_DRIVE);
    wire        wr_point    = wr && (addr == `A_OUT_POINT);
    wire        wr_strobe   = wr && (addr == `A_STROBE);
    wire [3:0]  pt_sel      = wdata[`PT_SEL_MSB:`PT_SEL_LSB];
    wire        rd_capture  = rd && (addr == `A_IN_CAPTURE);
    wire        rd_record   = rd && (addr == `A_RECORD);
    wire        wr_reload   = wr && (addr[7:4] == `A_RELOAD_BASE >> 4);
    wire        wr_edge_sel = wr && (addr == `A_EDGE_SEL);
    wire        wr_both_sel = wr && (addr == `A_BOTH_SEL);
    wire        wr_wrap_sel = wr && (addr == `A_WRAP_SEL);
    wire        wr_mask     = wr && (addr == `A_MASK);
    wire        wr_config   = wr && (addr == `A_CONFIG);
    wire        rd_with_stb = rd_capture && with_stb;

    // ------------------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------------------
    wire        out_strobe  = ((wr_field || wr_point) && with_stb)
                              || (wr_strobe && wdata[`SB_OUT_BIT]);
    wire        int_strobe  = (rd_capture && with_stb)
                              || (wr_strobe && wdata[`SB_IN_BIT]);
    wire        ext_edge    = rise_q ? (stb_q && !stb_prev_q) : (!stb_q && stb_prev_q);
    wire        cap_event   = ext_en_q ? ext_edge : int_strobe;

    // ------------------------------------------------------------------------
    // Output staging
    // ------------------------------------------------------------------------
    reg  [15:0] stage_d;
    always @* begin
        stage_d = stage_q;
        if (wr_field) begin
            stage_d = wdata[15:0];
        end else if (wr_point) begin
            stage_d[pt_sel] = wdata[`PT_VALUE_BIT];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_q   <= `RST_FIELD;
            field_out <= `RST_FIELD;
        end else begin
            stage_q <= stage_d;
            if (out_strobe) begin
                field_out <= stage_d;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Event configuration registers
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edge_sel_q <= `RST_FIELD;
        end else if (wr_edge_sel) begin
            edge_sel_q <= wdata[15:0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            both_sel_q <= `RST_FIELD;
        end else if (wr_both_sel) begin
            both_sel_q <= wdata[15:0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrap_sel_q <= `RST_FIELD;
        end else if (wr_wrap_sel) begin
            wrap_sel_q <= wdata[15:0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= `RST_FIELD;
        end else if (wr_mask) begin
            mask_q <= wdata[15:0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_en_q <= 1'b0;
            rise_q   <= 1'b0;
        end else if (wr_config) begin
            ext_en_q <= wdata[`CFG_EXT_BIT];
            rise_q   <= wdata[`CFG_RISE_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Input capture and strobe wait status
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capture_q <= `RST_FIELD;
            wait_q    <= 1'b1;
        end else if (cap_event && (wait_q || rd_with_stb)) begin
            capture_q <= in_q;
            wait_q    <= rd_capture;
        end else if (rd_capture) begin
            wait_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Event scanner
    // ------------------------------------------------------------------------
    reg  [3:0]  scan_pt_q;
    reg  [15:0] tick_q;
    wire        tick = (tick_q == SCAN_CYCLES[15:0] - 16'h0001);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_q    <= 16'h0000;
            scan_pt_q <= 4'h0;
        end else begin
            tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
            if (tick) begin
                scan_pt_q <= scan_pt_q + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Per-point detection, counting and recording
    // ------------------------------------------------------------------------
    wire [15:0] scaled;
    wire [7:0]  count [0:15];
    wire [7:0]  reload [0:15];

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : point
            reg  [7:0] count_q;
            reg  [7:0] reload_q;
            reg        past_bit_q;
            wire       sample = tick && (scan_pt_q == g);
            wire       change = sample && (in_q[g] != past_bit_q);
            wire       hit    = change && (both_sel_q[g]
                                 || (in_q[g] == edge_sel_q[g]));
            wire       load   = wr_reload && (addr[3:0] == g);
            assign scaled[g] = hit && (count_q == 8'hff);
            assign count[g]  = count_q;
            assign reload[g] = reload_q;
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    past_bit_q <= 1'b0;
                    count_q    <= `RST_COUNT;
                    reload_q   <= `RST_COUNT;
                end else begin
                    if (sample) begin
                        past_bit_q <= in_q[g];
                    end
                    if (load) begin
                        reload_q <= wdata[7:0];
                        count_q  <= wdata[7:0];
                    end else if (hit) begin
                        if (count_q != 8'hff) begin
                            count_q <= count_q + 8'h01;
                        end else if (wrap_sel_q[g]) begin
                            count_q <= reload_q;
                        end else begin
                            count_q <= 8'h00;
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Scaled-event record and interrupt
    // ------------------------------------------------------------------------
    wire [15:0] unmasked = scaled & mask_q;
    wire [15:0] kept     = rd_record ? 16'h0000 : record_q;
    wire        any_new  = (unmasked != 16'h0000);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            record_q <= `RST_FIELD;
        end else begin
            record_q <= kept | unmasked;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_ff_q <= 1'b0;
        end else if (any_new) begin
            irq_ff_q <= 1'b1;
        end else if (rd_record) begin
            irq_ff_q <= 1'b0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_enable && (irq_ff_q || any_new)
                   && !(rd_record && !any_new);
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    reg  [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h00000000;
        case (addr)
            `A_OUT_DRIVE:  rdata_d = second_word ? {16'h0000, stage_q}
                                                 : {16'h0000, field_out};
            `A_OUT_STAGE:  rdata_d = {16'h0000, stage_q};
            `A_IN_LIVE:    rdata_d = {16'h0000, in_q};
            `A_IN_CAPTURE: rdata_d = {16'h0000, (cap_event && with_stb) ? in_q : capture_q};
            `A_STATUS:     rdata_d = {31'h00000000, wait_q};
            `A_CONFIG:     rdata_d = {23'h000000, rise_q, 7'h00, ext_en_q};
            `A_EDGE_SEL:   rdata_d = {16'h0000, edge_sel_q};
            `A_BOTH_SEL:   rdata_d = {16'h0000, both_sel_q};
            `A_WRAP_SEL:   rdata_d = {16'h0000, wrap_sel_q};
            `A_MASK:       rdata_d = {16'h0000, mask_q};
            `A_RECORD:     rdata_d = {16'h0000, record_q | unmasked};
            default: begin
                if (addr[7:4] == `A_COUNT_BASE >> 4) begin
                    rdata_d = {24'h000000, count[addr[3:0]]};
                end else if (addr[7:4] == `A_RELOAD_BASE >> 4) begin
                    rdata_d = {24'h000000, reload[addr[3:0]]};
                end
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? rdata_d : 32'h00000000;
        end
    end

endmodule

// ==== tb/dio_event_card_asserts.sv ====
// Checker for the card's register port, output drive and interrupt level.
// Assumes it is bound to the card's top module and one clock domain.
`timescale 1ns/1ps
`include "dio_event_map.vh"
module dio_event_card_asserts #(
    parameter integer SCAN_CYCLES = `SCAN_CYCLES
) (
    // Clock and reset
    input wire        clk,
    input wire        rstn,
    // Host port
    input wire        wr,
    input wire        rd,
    input wire        second_word,
    input wire        irq_enable,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire [31:0] rdata,
    // Field pins
    input wire [15:0] field_in,
    input wire [15:0] field_out,
    input wire        ext_strobe,
    input wire        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_stage_write;
        wr && addr == `A_OUT_DRIVE;
    endsequence
    sequence s_stage_read;
        rd && addr == `A_OUT_STAGE;
    endsequence
    a_reset_open: assert property ($rose(rstn) |-> field_out == 16'h0000 && !irq)
        else $error("outputs not open after reset");
    a_stage_read: assert property (s_stage_write ##1 s_stage_read |=>
        rdata[15:0] == $past(wdata[15:0], 2)) else $error("staging read wrong");
    a_strobe_write: assert property (wr && addr == `A_OUT_DRIVE && wdata[`WR_STROBE_BIT]
        |=> field_out == $past(wdata[15:0])) else $error("strobed write not driven");
    a_nostrobe_keep: assert property (wr && addr == `A_OUT_DRIVE
        && !wdata[`WR_STROBE_BIT] |=> $stable(field_out)) else $error("drive moved early");
    a_drive_cause: assert property (!$stable(field_out) |-> $past(wr) &&
        ($past(addr) == `A_OUT_DRIVE || $past(addr) == `A_OUT_POINT
        || $past(addr) == `A_STROBE)) else $error("drive changed without strobe");
    a_drive_read: assert property (rd && addr == `A_OUT_DRIVE && !second_word
        |=> rdata[15:0] == $past(field_out)) else $error("one-word read wrong");
    a_rdata_idle: assert property ($past(rd) || rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_irq_hold: assert property (irq && !(rd && addr == `A_RECORD) ##1 irq_enable
        |-> irq) else $error("interrupt dropped before read");
    a_irq_gated: assert property (!irq_enable ##1 !irq_enable |-> !irq)
        else $error("interrupt passed while disabled");
endmodule
bind dio_event_card dio_event_card_asserts #(.SCAN_CYCLES(SCAN_CYCLES)) chk_u (
    .clk(clk), .rstn(rstn), .wr(wr), .rd(rd), .second_word(second_word),
    .irq_enable(irq_enable), .addr(addr), .wdata(wdata), .rdata(rdata),
    .field_in(field_in), .field_out(field_out), .ext_strobe(ext_strobe), .irq(irq));

// ==== tb/host_model.sv ====
// Host processor model: drives the card's register port.
// Assumes each access is started just after a rising clock edge.
`timescale 1ns/1ps
module host_model (
    // Clock and read data
    input  wire        clk,
    input  wire [31:0] rdata,
    // Register port
    output reg  [7:0]  addr,
    output reg  [31:0] wdata,
    output reg         wr,
    output reg         rd,
    output reg         second_word,
    output reg         irq_enable
);
    initial begin
        {addr, wdata, wr, rd, second_word, irq_enable} = '0;
    end
    // Writes whole words, a field or a single point.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bus_read(input logic [7:0] a, input logic sw, input logic str,
                            output logic [31:0] d);
        addr <= a;
        second_word <= sw;
        wdata <= {15'h0000, str, 16'h0000};
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // Releases the port; the released lines no longer show the last value.
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        wdata <= ~wdata;
        addr <= ~addr;
        repeat (n) @(posedge clk);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench of the input/output event counter card.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`include "dio_event_map.vh"
module tb_top;
    logic        clk;
    logic        rstn;
    logic        ext_strobe;
    logic        irq;
    logic [15:0] field_in;
    logic [15:0] field_out;
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        ext_strobe = 1'b0;
        field_in = 16'h0000;
    end
    logic [31:0] wdata, rdata;
    logic [7:0]  addr;
    logic        wr, rd, second_word, irq_enable;
    int fails = 0, n_compared = 0;
    always #20 clk = ~clk;
    host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .second_word(second_word), .irq_enable(irq_enable));
    dio_event_card #(.SCAN_CYCLES(2)) dut_u (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .second_word(second_word),
        .irq_enable(irq_enable), .rdata(rdata), .field_in(field_in),
        .ext_strobe(ext_strobe), .field_out(field_out), .irq(irq));
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic sw, input logic [31:0] e,
                        input string what);
        logic [31:0] d;
        host_u.bus_read(a, sw, 1'b0, d);
        check(what, d, e);
    endtask
    task automatic complete_run;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic t_reset;
        check("field_out", field_out, 32'h0);
        rchk(`A_STATUS, 1'b0, 32'h1, "status");
        rchk(8'h0f, 1'b0, 32'h0, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_output;
        host_u.bus_write(`A_OUT_DRIVE, 32'h0000_a5c3);
        rchk(`A_OUT_STAGE, 1'b0, 32'ha5c3, "staging");
        check("drive held", field_out, 32'h0);
        rchk(`A_OUT_DRIVE, 1'b1, 32'ha5c3, "second word");
        rchk(`A_OUT_DRIVE, 1'b0, 32'h0, "first word");
        host_u.bus_write(`A_STROBE, 32'h1);
        host_u.idle(1);
        check("strobed", field_out, 32'ha5c3);
        host_u.bus_write(`A_OUT_POINT, 32'h0001_0301);
        host_u.idle(1);
        check("point", field_out, 32'ha5cb);
        host_u.bus_write(`A_OUT_DRIVE, 32'h0001_8001);
        host_u.idle(1);
        check("field", field_out, 32'h8001);
        $display("test output done");
    endtask
    task automatic t_capture;
        logic [31:0] d;
        field_in <= 16'h1234;
        host_u.idle(6);
        host_u.bus_write(`A_STROBE, 32'h2);
        host_u.idle(2);
        rchk(`A_STATUS, 1'b0, 32'h0, "wait clear");
        field_in <= 16'hfedc;
        host_u.bus_write(`A_STROBE, 32'h2);
        host_u.idle(6);
        rchk(`A_IN_CAPTURE, 1'b0, 32'h1234, "held");
        rchk(`A_STATUS, 1'b0, 32'h1, "wait set");
        rchk(`A_IN_LIVE, 1'b0, 32'hfedc, "live");
        host_u.bus_read(`A_IN_CAPTURE, 1'b0, 1'b1, d);
        check("read strobe", d, 32'hfedc);
        host_u.bus_write(`A_CONFIG, 32'h0000_0101);
        field_in <= 16'h0f0f;
        host_u.idle(6);
        ext_strobe <= 1'b1;
        host_u.idle(6);
        ext_strobe <= 1'b0;
        field_in <= 16'h0000;
        host_u.idle(6);
        rchk(`A_IN_CAPTURE, 1'b0, 32'h0f0f, "ext rise");
        host_u.bus_write(`A_CONFIG, 32'h0);
        host_u.idle(80);
        $display("test capture done");
    endtask
    task automatic t_events;
        host_u.bus_write(`A_EDGE_SEL, 32'h1);
        host_u.bus_write(`A_BOTH_SEL, 32'h2);
        host_u.bus_write(`A_WRAP_SEL, 32'h1);
        host_u.bus_write(`A_MASK, 32'h1);
        host_u.bus_write(`A_RELOAD_BASE, 32'hfe); // 256 minus two events
        host_u.bus_write(`A_RELOAD_BASE + 8'h01, 32'hff);
        rchk(`A_COUNT_BASE, 1'b0, 32'hfe, "preset load");
        field_in <= 16'h0001;
        host_u.idle(80);
        rchk(`A_COUNT_BASE, 1'b0, 32'hff, "rise");
        field_in <= 16'h0000;
        host_u.idle(80);
        rchk(`A_COUNT_BASE, 1'b0, 32'hff, "fall ignored");
        field_in <= 16'h0001;
        host_u.idle(80);
        rchk(`A_COUNT_BASE, 1'b0, 32'hfe, "prescale");
        check("irq off", irq, 32'h0);
        host_u.irq_enable <= 1'b1;
        field_in <= 16'h0003;
        host_u.idle(80);
        check("irq on", irq, 32'h1);
        rchk(`A_COUNT_BASE + 8'h01, 1'b0, 32'h0, "totalize");
        rchk(`A_RECORD, 1'b0, 32'h1, "record");
        check("irq cleared", irq, 32'h0);
        rchk(`A_RECORD, 1'b0, 32'h0, "record cleared");
        $display("test events done");
    endtask
    initial begin
        #(40 * 5000);
        fails++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_output;
        t_capture;
        t_events;
        complete_run;
    end
endmodule
